// >>> verilog/cbg_glue.sv
// Processor card glue: waits, decode, clock, reset and bus gating
// Notes on behaviour
// - Wait low on ready, extra-ready or generator
// - Separate fetch, I/O, memory wait enables
// - One setting picks one or two waits
// - Bus ready waits ignore length setting
// - All on-board wait enables off by default
// - Common reset from ext-clear or bus reset
// - System clock 4 MHz default, 2 MHz option
// - Power-fail drives NMI when enabled
// - Refresh driven to bus, enabled by default
// - Memory request to bus, disabled by default
// - Serial B clock from timer or external
// - Decode only when A7-A5 match block
// - Each peripheral picks own A4-A2 slot
// - Unassigned block addresses get no response
// - Grounded block strap makes base bit one
// - Default slots 10H,14H,18H,1CH
// - Unused DMA ready input held high
`timescale 1ns/1ps
module cbg_glue (
   input  wire logic       clk,
   input  wire logic       reset,
   // Straps, sampled as levels
   input  wire logic       wait_fetch_en,
   input  wire logic       wait_io_en,
   input  wire logic       wait_mem_en,
   input  wire logic       wait_len_two,
   input  wire logic       reset_from_bus,
   input  wire logic       clk_slow_sel,
   input  wire logic       powerfail_route_enable,
   input  wire logic       refresh_out_enable,
   input  wire logic       mreq_out_enable,
   input  wire logic       serb_ext_clk_sel,
   input  wire logic [2:0] block_ground_n,
   input  wire logic [2:0] slot_pio,
   input  wire logic [2:0] slot_dma,
   input  wire logic [2:0] slot_tmr,
   input  wire logic [2:0] slot_ser,
   // Processor side
   input  wire logic       cpu_m1_n,
   input  wire logic       cpu_mreq_n,
   input  wire logic       cpu_iorq_n,
   input  wire logic       cpu_refresh_out_enable_n,
   input  wire logic [7:0] cpu_addr,
   output logic            cpu_wait_n,
   output logic            cpu_nmi_n,
   // Backplane
   input  wire logic       bus_rdy,
   input  wire logic       bus_xrdy,
   input  wire logic       bus_ext_clr_n,
   input  wire logic       bus_reset_n,
   input  wire logic       bus_pwrfail_n,
   output logic            bus_refresh_n,
   output logic            bus_refresh_oe,
   output logic            bus_mreq_n,
   output logic            bus_mreq_oe,
   // On-board peripherals
   input  wire logic       timer_ch2_clk,
   input  wire logic       ext_serb_clk,
   input  wire logic       dma_rdy_pad,
   input  wire logic       dma_rdy_pad_used,
   output logic            serb_clk,
   output logic            dma_rdy,
   output logic            board_reset_n,
   output logic            sys_clk,
   output logic            parallel_io_unit_sel_n,
   output logic            dma_unit_sel_n,
   output logic            timer_unit_sel_n,
   output logic            serial_io_unit_sel_n
);

   // Three-stage input sync; change accepted when stages 2 and 3 agree
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] sy1_q;
   logic [NSYNC-1:0] sy2_q;
   logic [NSYNC-1:0] sy3_q;
   logic [NSYNC-1:0] syf_q;
   logic [NSYNC-1:0] raw_in;

   assign raw_in = {bus_rdy, bus_xrdy, bus_ext_clr_n, bus_reset_n,
                    bus_pwrfail_n, timer_ch2_clk, ext_serb_clk,
                    dma_rdy_pad, 1'b0};

   always_ff @(posedge clk) begin
      if (reset) begin
         sy1_q <= 9'h1ff;
         sy2_q <= 9'h1ff;
         sy3_q <= 9'h1ff;
         syf_q <= 9'h1ff;
      end else begin
         sy1_q <= raw_in;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         // Take the level once stages 2 and 3 agree, else hold
         syf_q <= (sy2_q & sy3_q) | (syf_q & (sy2_q ^ sy3_q));
      end
   end

   logic s_rdy;
   logic s_xrdy;
   logic s_ext_clr_n;
   logic s_bus_reset_n;
   logic s_pwrfail_n;
   logic s_tmr2;
   logic s_extb;
   logic s_dma_pad;

   assign s_rdy         = syf_q[8];
   assign s_xrdy        = syf_q[7];
   assign s_ext_clr_n   = syf_q[6];
   assign s_bus_reset_n = syf_q[5];
   assign s_pwrfail_n   = syf_q[4];
   assign s_tmr2        = syf_q[3];
   assign s_extb        = syf_q[2];
   assign s_dma_pad     = syf_q[1];

   // Straps caught after reset release, held steady afterwards
   cbg_pkg::cbg_wait_cfg_t wcfg_q;
   logic       rst_bus_q;
   logic       slow_q;
   logic       pwr_q;
   logic       refresh_out_enable_q;
   logic       mreq_q;
   logic       extb_q;
   logic [2:0] base_q;
   logic       strap_taken_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         wcfg_q        <= {cbg_pkg::WAIT_FETCH_EN_RST,
                           cbg_pkg::WAIT_IO_EN_RST,
                           cbg_pkg::WAIT_MEM_EN_RST,
                           cbg_pkg::WAIT_LEN_TWO_RST};
         rst_bus_q     <= cbg_pkg::RESET_FROM_BUS_RST;
         slow_q        <= cbg_pkg::CLK_SLOW_RST;
         pwr_q         <= cbg_pkg::PWRFAIL_EN_RST;
         refresh_out_enable_q        <= cbg_pkg::REFRESH_EN_RST;
         mreq_q        <= cbg_pkg::MREQ_EN_RST;
         extb_q        <= cbg_pkg::SERB_EXT_CLK_RST;
         base_q        <= cbg_pkg::BLOCK_BASE_RST;
         strap_taken_q <= 1'b0;
      end else if (!strap_taken_q) begin
         wcfg_q        <= {wait_fetch_en, wait_io_en, wait_mem_en,
                           wait_len_two};
         rst_bus_q     <= reset_from_bus;
         slow_q        <= clk_slow_sel;
         pwr_q         <= powerfail_route_enable;
         refresh_out_enable_q        <= refresh_out_enable;
         mreq_q        <= mreq_out_enable;
         extb_q        <= serb_ext_clk_sel;
         base_q        <= ~block_ground_n;
         strap_taken_q <= 1'b1;
      end
   end

   logic rst_src_n;
   assign rst_src_n = rst_bus_q ? s_bus_reset_n : s_ext_clr_n;

   // system clock divider, rate from strap
   logic [4:0] div_q;
   logic       sclk_q;
   logic [4:0] half;
   logic       tick;

   assign half = slow_q ? cbg_pkg::SLOW_HALF : cbg_pkg::FAST_HALF;
   assign tick = (div_q == half - 5'h1) & sclk_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         div_q  <= 5'h0;
         sclk_q <= 1'b0;
      end else if (div_q >= half - 5'h1) begin
         div_q  <= 5'h0;
         sclk_q <= ~sclk_q;
      end else begin
         div_q  <= div_q + 5'h1;
      end
   end

   // Processor cycle status decode
   cbg_pkg::cbg_cycle_t cyc;
   assign cyc.fetch   = ~cpu_m1_n & ~cpu_mreq_n;
   assign cyc.mem     = ~cpu_mreq_n & cpu_refresh_out_enable_n;
   assign cyc.io      = ~cpu_iorq_n & cpu_m1_n;
   assign cyc.refresh = ~cpu_refresh_out_enable_n;

   logic gen_wait;
   cbg_wait_gen u_wait (
      .clk      (clk),
      .reset    (reset),
      .sys_tick (tick),
      .cycle    (cyc),
      .cfg      (wcfg_q),
      .wait_req (gen_wait)
   );

   cbg_pkg::cbg_sel_t sel;
   cbg_port_decode u_dec (
      .io_cycle   (cyc.io),
      .addr       (cpu_addr),
      .block_base (base_q),
      .slot_pio   (slot_pio),
      .slot_dma   (slot_dma),
      .slot_tmr   (slot_tmr),
      .slot_ser   (slot_ser),
      .sel        (sel)
   );

   // Registered outputs
   logic rst_out_q;
   logic nmi_q;
   logic serb_q;
   logic dma_q;
   cbg_pkg::cbg_sel_t sel_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         rst_out_q <= 1'b0;
         nmi_q     <= 1'b1;
         serb_q    <= 1'b0;
         dma_q     <= 1'b1;
         sel_q     <= '0;
      end else begin
         rst_out_q <= rst_src_n;
         nmi_q     <= ~(pwr_q & ~s_pwrfail_n);
         serb_q    <= extb_q ? s_extb : s_tmr2;
         dma_q     <= dma_rdy_pad_used ? s_dma_pad : 1'b1;
         sel_q     <= sel;
      end
   end

   // wait from any of three sources
   // bus waits follow the bus lines only
   assign cpu_wait_n     = ~(~s_rdy | ~s_xrdy | gen_wait);
   assign cpu_nmi_n      = nmi_q;
   assign bus_refresh_n  = cpu_refresh_out_enable_n;
   assign bus_refresh_oe = refresh_out_enable_q;
   // memory request gated onto the bus
   assign bus_mreq_n     = cpu_mreq_n;
   assign bus_mreq_oe    = mreq_q;
   assign serb_clk       = serb_q;
   assign dma_rdy        = dma_q;
   assign board_reset_n  = rst_out_q;
   assign sys_clk        = sclk_q;
   assign parallel_io_unit_sel_n = ~sel_q.parallel_io_unit;
   assign dma_unit_sel_n         = ~sel_q.dma;
   assign timer_unit_sel_n       = ~sel_q.tmr;
   assign serial_io_unit_sel_n   = ~sel_q.ser;

   chk_wait_bus_rdy: assert property (@(posedge clk) disable iff (reset)
      !s_rdy || !s_xrdy |-> !cpu_wait_n)
      else $error("bus ready low without processor wait");

   chk_sel_io_only: assert property (@(posedge clk) disable iff (reset)
      !cyc.io |=> sel_q == '0)
      else $error("select outside I/O cycle");

   chk_sel_block: assert property (@(posedge clk) disable iff (reset)
      sel != '0 |-> cpu_addr[7:5] == base_q)
      else $error("select outside block");

   chk_nmi_route: assert property (@(posedge clk) disable iff (reset)
      pwr_q && !s_pwrfail_n |=> !cpu_nmi_n)
      else $error("power-fail not routed to NMI");

   chk_nmi_quiet: assert property (@(posedge clk) disable iff (reset)
      !pwr_q && $past(!pwr_q) |-> cpu_nmi_n)
      else $error("NMI asserted with routing off");

   chk_dma_idle: assert property (@(posedge clk) disable iff (reset)
      !dma_rdy_pad_used |=> dma_rdy)
      else $error("unused DMA ready not high");

   chk_reset_src: assert property (@(posedge clk) disable iff (reset)
      strap_taken_q && $stable(rst_bus_q)
      |=> board_reset_n == $past(rst_src_n))
      else $error("board reset not from chosen source");

   chk_mreq_gate: assert property (@(posedge clk) disable iff (reset)
      strap_taken_q |-> bus_mreq_oe == mreq_q && bus_refresh_oe == refresh_out_enable_q)
      else $error("bus drive enables wrong");

endmodule : cbg_glue

// >>> verilog/cbg_pkg.sv
// Shared constants and carrier types for the processor card glue logic
package cbg_pkg;

   // Default strap settings
   localparam logic       WAIT_FETCH_EN_RST = 1'b0;
   localparam logic       WAIT_IO_EN_RST    = 1'b0;
   localparam logic       WAIT_MEM_EN_RST   = 1'b0;
   localparam logic       WAIT_LEN_TWO_RST  = 1'b0;
   localparam logic       RESET_FROM_BUS_RST = 1'b0;
   localparam logic       CLK_SLOW_RST      = 1'b0;
   localparam logic       PWRFAIL_EN_RST    = 1'b0;
   localparam logic       REFRESH_EN_RST    = 1'b1;
   localparam logic       MREQ_EN_RST       = 1'b0;
   localparam logic       SERB_EXT_CLK_RST  = 1'b0;

   // Block base straps: grounded (0) means base bit set
   localparam logic [2:0] BLOCK_BASE_RST    = 3'h0;
   // default slots 10H, 14H, 18H, 1CH
   localparam logic [2:0] SLOT_PIO_RST      = 3'h4;
   localparam logic [2:0] SLOT_DMA_RST      = 3'h5;
   localparam logic [2:0] SLOT_TMR_RST      = 3'h6;
   localparam logic [2:0] SLOT_SER_RST      = 3'h7;

   // Address field positions
   localparam int         BLK_LSB           = 5;
   localparam int         SLOT_LSB          = 2;

   // Wait lengths in system clock cycles
   localparam logic [1:0] WAIT_SHORT        = 2'h1;
   localparam logic [1:0] WAIT_LONG         = 2'h2;

   // System clock rates and divide ratios from the 40 MHz clock
   localparam int         CLK_HZ            = 40000000;
   localparam int         FAST_HZ           = 4000000;
   localparam int         SLOW_HZ           = 2000000;
   localparam logic [4:0] FAST_HALF = 5'(CLK_HZ / FAST_HZ / 2);
   localparam logic [4:0] SLOW_HALF = 5'(CLK_HZ / SLOW_HZ / 2);

   // Processor cycle status, active high
   typedef struct packed {
      logic fetch;
      logic mem;
      logic io;
      logic refresh;
   } cbg_cycle_t;

   // Wait configuration
   typedef struct packed {
      logic fetch_en;
      logic io_en;
      logic mem_en;
      logic len_two;
   } cbg_wait_cfg_t;

   // Chip selects, active high internally
   typedef struct packed {
      logic parallel_io_unit;
      logic dma;
      logic tmr;
      logic ser;
   } cbg_sel_t;

   typedef enum logic [2:0] {
      WG_IDLE = 3'b001,
      WG_WAIT = 3'b010,
      WG_DONE = 3'b100
   } cbg_wg_state_t;

endpackage : cbg_pkg

// >>> verilog/cbg_wait_gen.sv
// On-board wait-state generator
`timescale 1ns/1ps
module cbg_wait_gen (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   sys_tick,
   input  wire cbg_pkg::cbg_cycle_t    cycle,
   input  wire cbg_pkg::cbg_wait_cfg_t cfg,
   output logic                        wait_req
);

   cbg_pkg::cbg_wg_state_t state_q;
   cbg_pkg::cbg_wg_state_t state_d;
   logic [1:0]             cnt_q;
   logic [1:0]             cnt_d;
   logic                   want;
   logic [1:0]             len;

   assign want = (cycle.fetch & cfg.fetch_en)
               | (cycle.io & cfg.io_en)
               | (cycle.mem & ~cycle.fetch & ~cycle.refresh & cfg.mem_en);
   assign len  = cfg.len_two ? cbg_pkg::WAIT_LONG : cbg_pkg::WAIT_SHORT;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         cbg_pkg::WG_IDLE: begin
            if (want) begin
               state_d = cbg_pkg::WG_WAIT;
               cnt_d   = len;
            end
         end
         cbg_pkg::WG_WAIT: begin
            if (sys_tick) begin
               cnt_d = cnt_q - 2'h1;
               if (cnt_q == 2'h1) begin
                  state_d = cbg_pkg::WG_DONE;
               end
            end
         end
         cbg_pkg::WG_DONE: begin
            // Hold off until the cycle ends so one cycle waits once
            if (!want) begin
               state_d = cbg_pkg::WG_IDLE;
            end
         end
         default: begin
            state_d = cbg_pkg::WG_IDLE;
            cnt_d   = 2'h0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= cbg_pkg::WG_IDLE;
         cnt_q   <= 2'h0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Combinational so the wait lands in the cycle that asks for it
   assign wait_req = (state_q == cbg_pkg::WG_WAIT)
                   | ((state_q == cbg_pkg::WG_IDLE) & want);

   // long wait held for at least two clock cycles
   chk_wait_len_long: assert property (@(posedge clk) disable iff (reset)
      $rose(state_q == cbg_pkg::WG_WAIT) && cnt_q == 2'h2
      |-> (state_q == cbg_pkg::WG_WAIT)[*2])
      else $error("long wait ended early");

   // no on-board wait with enables off
   chk_wait_off: assert property (@(posedge clk) disable iff (reset)
      !cfg.fetch_en && !cfg.io_en && !cfg.mem_en
      && state_q == cbg_pkg::WG_IDLE |-> !wait_req)
      else $error("wait raised with all enables off");

endmodule : cbg_wait_gen

// >>> verilog/cbg_port_decode.sv
// Peripheral chip-select decoder for the 32-address I/O block
`timescale 1ns/1ps
module cbg_port_decode (
   input  wire logic              io_cycle,
   input  wire logic [7:0]        addr,
   input  wire logic [2:0]        block_base,
   input  wire logic [2:0]        slot_pio,
   input  wire logic [2:0]        slot_dma,
   input  wire logic [2:0]        slot_tmr,
   input  wire logic [2:0]        slot_ser,
   output cbg_pkg::cbg_sel_t      sel
);

   logic       blk_hit;
   logic [2:0] slot;

   function automatic logic slot_hit(input logic [2:0] a,
                                     input logic [2:0] s);
      slot_hit = (a == s);
   endfunction : slot_hit

   assign blk_hit  = io_cycle
                   & (addr[cbg_pkg::BLK_LSB +: 3] == block_base);
   assign slot     = addr[cbg_pkg::SLOT_LSB +: 3];
   assign sel.parallel_io_unit  = blk_hit & slot_hit(slot, slot_pio);
   assign sel.dma  = blk_hit & slot_hit(slot, slot_dma);
   assign sel.tmr  = blk_hit & slot_hit(slot, slot_tmr);
   assign sel.ser  = blk_hit & slot_hit(slot, slot_ser);

endmodule : cbg_port_decode

// >>> verif/cbg_cpu_model.sv
// Processor model issuing one bus cycle at a time
`timescale 1ns/1ps
module cbg_cpu_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [1:0] kind,
   input  wire logic [7:0] addr_in,
   input  wire logic       cpu_wait_n,
   output logic            m1_n,
   output logic            mreq_n,
   output logic            iorq_n,
   output logic            refresh_out_enable_n,
   output logic [7:0]      addr,
   output logic            busy
);
   // Kind: 0 fetch, 1 memory, 2 I/O, 3 refresh
   logic [1:0] t_q;

   initial begin
      {m1_n, mreq_n, iorq_n, refresh_out_enable_n, busy} = 5'h1e;
      addr = 8'h00;
      t_q = 2'h0;
   end

   always @(posedge clk) begin
      if (go && !busy) begin
         busy   <= 1'b1;
         t_q    <= 2'h0;
         addr   <= addr_in;
         m1_n   <= kind != 2'h0;
         mreq_n <= kind == 2'h2;
         iorq_n <= kind != 2'h2;
         refresh_out_enable_n <= kind != 2'h3;
      end else if (busy && t_q != 2'h2) begin
         t_q <= t_q + 2'h1;
      end else if (busy && cpu_wait_n) begin
         // Released lines show the inverse, never the old address
         {m1_n, mreq_n, iorq_n, refresh_out_enable_n, busy} <= 5'h1e;
         addr <= ~addr;
      end
   end
endmodule : cbg_cpu_model

// >>> verif/cbg_glue_tb_top.sv
// Random and directed bench for the processor card glue
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin \
   error_cnt++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module cbg_glue_tb_top;
   logic       clk, reset, go, rfo, mqo;
   logic       wf, wi, wm, wl, rfb, slow, pwr, rfe, mqe, sbe;
   logic [2:0] gnd_n, r;
   logic [2:0] sl [4];
   logic [1:0] kind, k;
   logic [7:0] ca, addr, a;
   logic       m1_n, mreq_n, iorq_n, refresh_out_enable_n, busy, wait_n, nmi_n;
   logic       rdy, xrdy, clr_n, brst_n, pf_n, tclk, eclk, pad, dpu;
   logic       serb_clk, dma_rdy, brd_rst_n, sys_clk;
   wire  [3:0] sel_n;
   logic [3:0] seen;
   int         error_cnt, checks, wlow, n, p, len;

   cbg_glue dut_u (
      .clk(clk), .reset(reset), .wait_fetch_en(wf), .wait_io_en(wi),
      .wait_mem_en(wm), .wait_len_two(wl), .reset_from_bus(rfb),
      .clk_slow_sel(slow), .powerfail_route_enable(pwr),
      .refresh_out_enable(rfe), .mreq_out_enable(mqe),
      .serb_ext_clk_sel(sbe), .block_ground_n(gnd_n), .slot_pio(sl[0]),
      .slot_dma(sl[1]), .slot_tmr(sl[2]), .slot_ser(sl[3]),
      .cpu_m1_n(m1_n), .cpu_mreq_n(mreq_n), .cpu_iorq_n(iorq_n),
      .cpu_refresh_out_enable_n(refresh_out_enable_n), .cpu_addr(addr), .cpu_wait_n(wait_n),
      .cpu_nmi_n(nmi_n), .bus_rdy(rdy), .bus_xrdy(xrdy),
      .bus_ext_clr_n(clr_n), .bus_reset_n(brst_n), .bus_pwrfail_n(pf_n),
      .bus_refresh_n(), .bus_refresh_oe(rfo), .bus_mreq_n(),
      .bus_mreq_oe(mqo), .timer_ch2_clk(tclk), .ext_serb_clk(eclk),
      .dma_rdy_pad(pad), .dma_rdy_pad_used(dpu), .serb_clk(serb_clk),
      .dma_rdy(dma_rdy), .board_reset_n(brd_rst_n), .sys_clk(sys_clk),
      .parallel_io_unit_sel_n(sel_n[3]), .dma_unit_sel_n(sel_n[2]),
      .timer_unit_sel_n(sel_n[1]), .serial_io_unit_sel_n(sel_n[0])
   );

   cbg_cpu_model cpu_u (
      .clk(clk), .go(go), .kind(kind), .addr_in(ca), .cpu_wait_n(wait_n),
      .m1_n(m1_n), .mreq_n(mreq_n), .iorq_n(iorq_n), .refresh_out_enable_n(refresh_out_enable_n),
      .addr(addr), .busy(busy)
   );

   function automatic logic [3:0] exp_sel(input logic [1:0] kk,
                                          input logic [7:0] aa);
      logic [3:0] m;
      for (int j = 0; j < 4; j++) m[3 - j] = aa[4:2] == sl[j];
      if (kk != 2'h2 || aa[7:5] != ~gnd_n) m = 4'h0;
      return m;
   endfunction : exp_sel

   function automatic logic wait_ok(input logic [1:0] kk, input int w);
      int  q;
      logic en;
      q = slow ? int'(cbg_pkg::SLOW_HALF) : int'(cbg_pkg::FAST_HALF);
      q = 2 * q;
      en = kk == 2'h0 ? wf : kk == 2'h1 ? wm : kk == 2'h2 ? wi : 1'b0;
      if (!en) return w == 0;
      return wl ? (w >= q && w <= 2 * q + 1) : (w >= 1 && w <= q + 1);
   endfunction : wait_ok

   task automatic wt(input int c);
      repeat (c) @(posedge clk);
   endtask : wt

   task automatic cyc(input logic [1:0] kk, input logic [7:0] aa);
      int c;
      seen = 4'h0;
      wlow = 0;
      c = 0;
      kind <= kk;
      ca <= aa;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1 && c < 200) begin
         seen |= ~sel_n;
         if (wait_n === 1'b0) wlow++;
         @(posedge clk);
         c++;
      end
      repeat (2) begin
         seen |= ~sel_n;
         @(posedge clk);
      end
   endtask : cyc

   task automatic per(output int c);
      logic q;
      int   e;
      c = 0;
      e = 0;
      q = sys_clk;
      repeat (100) begin
         @(posedge clk);
         if (e == 1) c++;
         if (sys_clk === 1'b1 && q === 1'b0) e++;
         if (e == 2) break;
         q = sys_clk;
      end
   endtask : per

   task automatic bus_wait(input logic x, input int ln, output int c);
      c = 0;
      for (int i = 0; i < ln + 12; i++) begin
         if (i == 0) begin
            rdy <= x;
            xrdy <= !x;
         end
         if (i == ln) begin
            rdy <= 1'b1;
            xrdy <= 1'b1;
         end
         @(posedge clk);
         if (wait_n === 1'b0) c++;
      end
   endtask : bus_wait

   task automatic do_reset(input logic dflt);
      reset <= 1'b1;
      if (dflt) begin
         wf <= cbg_pkg::WAIT_FETCH_EN_RST;
         wi <= cbg_pkg::WAIT_IO_EN_RST;
         wm <= cbg_pkg::WAIT_MEM_EN_RST;
         wl <= cbg_pkg::WAIT_LEN_TWO_RST;
         rfb <= cbg_pkg::RESET_FROM_BUS_RST;
         slow <= cbg_pkg::CLK_SLOW_RST;
         pwr <= cbg_pkg::PWRFAIL_EN_RST;
         rfe <= cbg_pkg::REFRESH_EN_RST;
         mqe <= cbg_pkg::MREQ_EN_RST;
         sbe <= cbg_pkg::SERB_EXT_CLK_RST;
         gnd_n <= ~cbg_pkg::BLOCK_BASE_RST;
         sl[0] <= cbg_pkg::SLOT_PIO_RST;
         sl[1] <= cbg_pkg::SLOT_DMA_RST;
         sl[2] <= cbg_pkg::SLOT_TMR_RST;
         sl[3] <= cbg_pkg::SLOT_SER_RST;
      end else begin
         {wf, wi, wm, wl, rfb, slow, pwr, rfe, mqe, sbe} <= 10'($urandom);
         gnd_n <= 3'($urandom);
         r = 3'($urandom);
         // Distinct slots in a rotated order
         for (int j = 0; j < 4; j++) sl[j] <= r + 3'(2 * j);
      end
      dpu <= 1'b0;
      wt(4);
      reset <= 1'b0;
      wt(10);
   endtask : do_reset

   task automatic close_out();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Generous span: the run needs about 2000 cycles
   initial begin
      wt(20000);
      error_cnt++;
      close_out();
   end

   initial begin
      reset = 1'b1;
      go = 1'b0;
      kind = 2'h0;
      ca = 8'h00;
      {rdy, xrdy, clr_n, brst_n, pf_n} = 5'h1f;
      {tclk, eclk, pad, dpu} = 4'h0;
      error_cnt = 0;
      checks = 0;
      void'($urandom(32'hffc4e9e1));
      // First pass runs the shipped strap settings
      for (int it = 0; it < 8; it++) begin
         do_reset(it == 0);
         for (int j = 0; j < 12; j++) begin
            k = j < 4 ? 2'h2 : 2'($urandom);
            a = j < 4 ? {~gnd_n, sl[j], 2'($urandom)} : 8'($urandom);
            if ((j % 2) == 1) a[7:5] = ~gnd_n;
            cyc(k, a);
            `CHK("sel", exp_sel(k, a), seen)
            `CHK("wait_len", 1'b1, wait_ok(k, wlow))
         end
         per(n);
         p = slow ? cbg_pkg::SLOW_HZ : cbg_pkg::FAST_HZ;
         `CHK("sys_clk_period", cbg_pkg::CLK_HZ / p, n)
         len = 5 + int'($urandom_range(15));
         bus_wait(it % 2 == 1, len, n);
         `CHK("bus_wait", 1'b1, n >= len - 1 && n <= len + 1)
         `CHK("refresh_out_enable_oe", rfe, rfo)
         `CHK("mreq_oe", mqe, mqo)
         clr_n <= 1'b0;
         wt(8);
         `CHK("brd_rst_clr", rfb, brd_rst_n)
         clr_n <= 1'b1;
         brst_n <= 1'b0;
         wt(8);
         `CHK("brd_rst_bus", !rfb, brd_rst_n)
         brst_n <= 1'b1;
         pf_n <= 1'b0;
         wt(8);
         `CHK("nmi", !pwr, nmi_n)
         pf_n <= 1'b1;
         tclk <= 1'b1;
         dpu <= 1'($urandom);
         wt(8);
         `CHK("serb_timer", !sbe, serb_clk)
         // pad passed as is when used, held high when unused
         `CHK("dma_rdy", !dpu, dma_rdy)
         tclk <= 1'b0;
         eclk <= 1'b1;
         wt(8);
         `CHK("serb_ext", sbe, serb_clk)
         eclk <= 1'b0;
      end
      close_out();
   end
endmodule : cbg_glue_tb_top
